/* hdl/rtc_time_pkg.sv */
// constants for the time value registers
package rtc_time_pkg;
	localparam logic [3:0] ADDR_WEEKDAY_HOURS = 4'h0;
	localparam logic [3:0] ADDR_MINUTES_SECONDS = 4'h4;
	localparam logic [3:0] ADDR_CONTROL = 4'h8;
	localparam int WEEKDAY_LSB = 8;
	localparam int HOUR_TENS_LSB = 4;
	localparam int HOUR_ONES_LSB = 0;
	localparam int MINUTE_TENS_LSB = 12;
	localparam int MINUTE_ONES_LSB = 8;
	localparam int SECOND_TENS_LSB = 4;
	localparam int SECOND_ONES_LSB = 0;
	localparam int UNLOCK_BIT = 0;
	localparam logic [2:0] WEEKDAY_MAX = 3'h6;
	localparam logic [1:0] HOUR_TENS_MAX = 2'h2;
	localparam logic [3:0] ONES_MAX = 4'h9;
	localparam logic [3:0] HOUR_ONES_LAST = 4'h3;
	localparam logic [2:0] TENS_MAX = 3'h5;
	localparam logic CONTROL_RESET = 1'h0;
	localparam longint CLOCK_HZ = 250000000;
	localparam longint SECOND_CYCLES = CLOCK_HZ;
endpackage

/* hdl/rtc_time_value_registers.sv */
// weekday, hour, minute and second value registers with wishbone slave
`timescale 1ns/100ps
module rtc_time_value_registers
	import rtc_time_pkg::*;
#(
	parameter longint TICK_CYCLES = SECOND_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	////////////////////////////////////////////////////////////////
	logic [2:0] weekday_digit;
	logic [1:0] hour_tens_digit;
	logic [3:0] hour_ones_digit;
	logic [2:0] minute_tens_digit;
	logic [3:0] minute_ones_digit;
	logic [2:0] second_tens_digit;
	logic [3:0] second_ones_digit;
	logic clock_write_unlock;
	logic [27:0] tick_count;
	logic tick;
	logic request;
	logic wr_wkhr;
	logic wr_minutes_seconds_value;
	logic [15:0] weekday_hours_value;
	logic [15:0] minutes_seconds_value;

	// next value of a tens digit that wraps after five
	function automatic logic [2:0] tens_step(input logic [2:0] d);
		return (d == TENS_MAX) ? 3'h0 : d + 3'h1;
	endfunction

	// next value of a ones digit that wraps after nine
	function automatic logic [3:0] ones_step(input logic [3:0] d);
		return (d == ONES_MAX) ? 4'h0 : d + 4'h1;
	endfunction

	assign weekday_hours_value = {5'h00, weekday_digit, 2'h0, hour_tens_digit,
		hour_ones_digit};
	assign minutes_seconds_value = {1'h0, minute_tens_digit, minute_ones_digit,
		1'h0, second_tens_digit, second_ones_digit};

	////////////////////////////////////////////////////////////////
	// wishbone slave, one wait state
	assign request = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_wkhr = request && wb_we_i && (wb_adr_i == ADDR_WEEKDAY_HOURS)
		&& clock_write_unlock;
	assign wr_minutes_seconds_value = request && wb_we_i && (wb_adr_i == ADDR_MINUTES_SECONDS)
		&& clock_write_unlock;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= request;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (request && !wb_we_i) begin
			if (wb_adr_i == ADDR_WEEKDAY_HOURS) begin
				wb_dat_o <= {16'h0000, weekday_hours_value};
			end else if (wb_adr_i == ADDR_MINUTES_SECONDS) begin
				wb_dat_o <= {16'h0000, minutes_seconds_value};
			end else if (wb_adr_i == ADDR_CONTROL) begin
				wb_dat_o <= {31'h00000000, clock_write_unlock};
			end else begin
				wb_dat_o <= 32'h00000000;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clock_write_unlock <= CONTROL_RESET;
		end else if (request && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADDR_CONTROL)) begin
			clock_write_unlock <= wb_dat_i[UNLOCK_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// one second tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_count <= 28'h0000000;
			tick <= 1'b0;
		end else if (tick_count == 28'(TICK_CYCLES - 1)) begin
			tick_count <= 28'h0000000;
			tick <= 1'b1;
		end else begin
			tick_count <= tick_count + 28'h0000001;
			tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// digits: no reset, value undefined at power-on; software write beats tick
	logic sec_wrap;
	logic min_wrap;
	logic hour_wrap;
	assign sec_wrap = (second_ones_digit == ONES_MAX) && (second_tens_digit == TENS_MAX);
	assign min_wrap = sec_wrap && (minute_ones_digit == ONES_MAX)
		&& (minute_tens_digit == TENS_MAX);
	assign hour_wrap = min_wrap && (hour_tens_digit == HOUR_TENS_MAX)
		&& (hour_ones_digit == HOUR_ONES_LAST);

	always_ff @(posedge clk_i) begin
		if (wr_minutes_seconds_value) begin
			if (wb_sel_i[0]) begin
				second_tens_digit <= wb_dat_i[SECOND_TENS_LSB +: 3];
				second_ones_digit <= wb_dat_i[SECOND_ONES_LSB +: 4];
			end
			if (wb_sel_i[1]) begin
				minute_tens_digit <= wb_dat_i[MINUTE_TENS_LSB +: 3];
				minute_ones_digit <= wb_dat_i[MINUTE_ONES_LSB +: 4];
			end
		end else if (tick) begin
			second_ones_digit <= ones_step(second_ones_digit);
			if (second_ones_digit == ONES_MAX) begin
				second_tens_digit <= tens_step(second_tens_digit);
			end
			if (sec_wrap) begin
				minute_ones_digit <= ones_step(minute_ones_digit);
				if (minute_ones_digit == ONES_MAX) begin
					minute_tens_digit <= tens_step(minute_tens_digit);
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_wkhr) begin
			if (wb_sel_i[0]) begin
				hour_tens_digit <= wb_dat_i[HOUR_TENS_LSB +: 2];
				hour_ones_digit <= wb_dat_i[HOUR_ONES_LSB +: 4];
			end
			if (wb_sel_i[1]) begin
				weekday_digit <= wb_dat_i[WEEKDAY_LSB +: 3];
			end
		end else if (tick && min_wrap) begin
			if (hour_wrap) begin
				hour_tens_digit <= 2'h0;
				hour_ones_digit <= 4'h0;
				weekday_digit <= (weekday_digit == WEEKDAY_MAX) ? 3'h0
					: weekday_digit + 3'h1;
			end else if (hour_ones_digit == ONES_MAX) begin
				hour_ones_digit <= 4'h0;
				hour_tens_digit <= hour_tens_digit + 2'h1;
			end else begin
				hour_ones_digit <= hour_ones_digit + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// checker helpers: digits are unknown until software loads them
	logic hours_loaded;
	logic minutes_seconds_value_loaded;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hours_loaded <= 1'b0;
		end else if (wr_wkhr && wb_sel_i[1:0] == 2'h3) begin
			hours_loaded <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			minutes_seconds_value_loaded <= 1'b0;
		end else if (wr_minutes_seconds_value && wb_sel_i[1:0] == 2'h3) begin
			minutes_seconds_value_loaded <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	weekday_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(request && wb_we_i && wb_adr_i == ADDR_WEEKDAY_HOURS && !clock_write_unlock
		&& !tick) |=> $stable(weekday_hours_value))
		else $error("locked weekday write changed value");

	minutes_seconds_value_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(request && wb_we_i && wb_adr_i == ADDR_MINUTES_SECONDS && !clock_write_unlock
		&& !tick) |=> $stable(minutes_seconds_value))
		else $error("locked minutes_seconds_value write changed value");

	read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");

	sec_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_minutes_seconds_value && second_ones_digit < ONES_MAX)
		|=> second_ones_digit == $past(second_ones_digit) + 4'h1)
		else $error("second ones did not step");

	sec_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_minutes_seconds_value && sec_wrap) |=> second_tens_digit == 3'h0
		&& second_ones_digit == 4'h0)
		else $error("seconds did not wrap");

	sec_tens_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_minutes_seconds_value && second_ones_digit == ONES_MAX && second_tens_digit < TENS_MAX)
		|=> second_tens_digit == $past(second_tens_digit) + 3'h1 && second_ones_digit == 4'h0)
		else $error("second tens did not step");

	min_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_minutes_seconds_value && sec_wrap && minute_ones_digit < ONES_MAX)
		|=> minute_ones_digit == $past(minute_ones_digit) + 4'h1)
		else $error("minute ones did not step");

	min_tens_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_minutes_seconds_value && sec_wrap && minute_ones_digit == ONES_MAX
		&& minute_tens_digit < TENS_MAX)
		|=> minute_tens_digit == $past(minute_tens_digit) + 3'h1 && minute_ones_digit == 4'h0)
		else $error("minute tens did not step");

	min_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_minutes_seconds_value && min_wrap) |=> minute_tens_digit == 3'h0
		&& minute_ones_digit == 4'h0)
		else $error("minutes did not wrap");

	min_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(minutes_seconds_value_loaded && tick && !wr_minutes_seconds_value && !sec_wrap)
		|=> $stable(minutes_seconds_value[14:8]))
		else $error("minutes moved without carry");

	minutes_seconds_value_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(minutes_seconds_value_loaded && !tick && !wr_minutes_seconds_value) |=> $stable(minutes_seconds_value))
		else $error("minutes_seconds_value moved without tick or write");

	hours_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(hours_loaded && !(tick && min_wrap) && !wr_wkhr) |=> $stable(weekday_hours_value))
		else $error("hours moved without carry or write");

	hour_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_wkhr && min_wrap && !hour_wrap && hour_ones_digit < ONES_MAX)
		|=> hour_ones_digit == $past(hour_ones_digit) + 4'h1 && $stable(hour_tens_digit))
		else $error("hour ones did not step");

	hour_tens_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_wkhr && min_wrap && hour_ones_digit == ONES_MAX)
		|=> hour_tens_digit == $past(hour_tens_digit) + 2'h1 && hour_ones_digit == 4'h0)
		else $error("hour tens did not step");

	hour_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_wkhr && !wr_minutes_seconds_value && hour_wrap) |=> hour_tens_digit == 2'h0
		&& hour_ones_digit == 4'h0)
		else $error("hours did not wrap");

	weekday_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_wkhr && min_wrap && !hour_wrap) |=> $stable(weekday_digit))
		else $error("weekday moved without day carry");

	weekday_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_wkhr && hour_wrap && weekday_digit < WEEKDAY_MAX)
		|=> weekday_digit == $past(weekday_digit) + 3'h1)
		else $error("weekday did not step");

	weekday_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick && !wr_wkhr && hour_wrap && weekday_digit == WEEKDAY_MAX)
		|=> weekday_digit == 3'h0)
		else $error("weekday did not wrap");

	ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		request |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not single cycle");

	ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!request |=> !wb_ack_o)
		else $error("ack without request");

	write_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_minutes_seconds_value && wb_sel_i == 4'hF) |=> minutes_seconds_value
		== {1'h0, $past(wb_dat_i[14:8]), 1'h0, $past(wb_dat_i[6:0])})
		else $error("minutes_seconds_value write not stored");

	hours_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_wkhr && wb_sel_i == 4'hF) |=> weekday_hours_value
		== {5'h00, $past(wb_dat_i[10:8]), 2'h0, $past(wb_dat_i[5:0])})
		else $error("hours write not stored");

	unlock_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(request && wb_we_i && wb_adr_i == ADDR_CONTROL && wb_sel_i[0])
		|=> clock_write_unlock == $past(wb_dat_i[UNLOCK_BIT]))
		else $error("unlock write not stored");

	unlock_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(request && wb_we_i && wb_adr_i == ADDR_CONTROL) |=> $stable(clock_write_unlock))
		else $error("unlock changed without write");

	read_hours_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(hours_loaded && request && !wb_we_i && wb_adr_i == ADDR_WEEKDAY_HOURS)
		|=> wb_dat_o == {16'h0000, $past(weekday_hours_value)})
		else $error("hours read data wrong");

	read_minutes_seconds_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(minutes_seconds_value_loaded && request && !wb_we_i && wb_adr_i == ADDR_MINUTES_SECONDS)
		|=> wb_dat_o == {16'h0000, $past(minutes_seconds_value)})
		else $error("minutes_seconds_value read data wrong");

	read_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(request && !wb_we_i) |=> $stable(wb_dat_o))
		else $error("read data changed without read");

	tick_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick |=> !tick)
		else $error("tick longer than one cycle");

	tick_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick_count <= 28'(TICK_CYCLES - 1))
		else $error("tick counter out of range");

endmodule

/* tb/rtc_time_value_registers_tb.sv */
// register-level testbench for the time value registers
`timescale 1ns/100ps
`define check(nm, exp, got) comparisons++; if ((got) !== (exp)) begin \
	$display("[FAIL] %s expected %h seen %h", nm, exp, got); fail_count++; end
module rtc_time_value_registers_tb;
	import rtc_time_pkg::*;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic wb_cyc_i = 1'h0;
	logic wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [31:0] rd;
	logic [31:0] hv [4] = '{32'h0612, 32'h0109, 32'h0020, 32'h0000};
	logic [31:0] hin [2] = '{32'h0319, 32'h0623};
	logic [31:0] hout [2] = '{32'h0320, 32'h0000};
	int fail_count = 0;
	int comparisons = 0;
	always #2 clk_i = ~clk_i;
	rtc_time_value_registers #(.TICK_CYCLES(40)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	// poll until the register no longer holds val, giving up after 41 reads
	task automatic wait_leave(input logic [3:0] adr, input logic [31:0] val);
		int n;
		n = 0;
		do wb(1'h0, adr, 32'h0); while (rd === val && n++ < 40);
	endtask
	task automatic wrap_up();
		if (fail_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(4 * 20000);
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(1'h0, ADDR_CONTROL, 32'h0);
		`check("control reset", 32'h0, rd)
		wb(1'h1, ADDR_CONTROL, 32'h1);
		wb(1'h0, ADDR_CONTROL, 32'h0);
		`check("control", 32'h1, rd)
		wb(1'h0, 4'hC, 32'h0);
		`check("unmapped", 32'h0, rd)
		wb(1'h1, ADDR_MINUTES_SECONDS, 32'hFFFF);
		wb(1'h0, ADDR_MINUTES_SECONDS, 32'h0);
		`check("minutes_seconds_value unused", 32'h0, rd & 32'hFFFF8080)
		wb(1'h1, ADDR_MINUTES_SECONDS, 32'h0);
		wb(1'h1, ADDR_WEEKDAY_HOURS, 32'hFFFF);
		wb(1'h0, ADDR_WEEKDAY_HOURS, 32'h0);
		`check("hours unused", 32'h0, rd & 32'hFFFFF8C0)
		for (int i = 0; i < 4; i++) begin
			wb(1'h1, ADDR_WEEKDAY_HOURS, hv[i]);
			wb(1'h0, ADDR_WEEKDAY_HOURS, 32'h0);
			`check("hours field", hv[i], rd)
		end
		for (int i = 0; i < 2; i++) begin
			wb(1'h1, ADDR_WEEKDAY_HOURS, hin[i]);
			// write just after a tick so the next one is far away
			wb(1'h0, ADDR_MINUTES_SECONDS, 32'h0);
			wait_leave(ADDR_MINUTES_SECONDS, rd);
			wb(1'h1, ADDR_MINUTES_SECONDS, 32'h5959);
			wb(1'h0, ADDR_MINUTES_SECONDS, 32'h0);
			`check("minutes_seconds_value field", 32'h5959, rd)
			wait_leave(ADDR_MINUTES_SECONDS, 32'h5959);
			`check("minutes_seconds_value roll", 32'h0, rd)
			wb(1'h0, ADDR_WEEKDAY_HOURS, 32'h0);
			`check("hours roll", hout[i], rd)
		end
		wb(1'h1, ADDR_CONTROL, 32'h0);
		wb(1'h1, ADDR_WEEKDAY_HOURS, 32'h0111);
		wb(1'h0, ADDR_WEEKDAY_HOURS, 32'h0);
		`check("locked write", hout[1], rd)
		wb(1'h1, ADDR_MINUTES_SECONDS, 32'h5900);
		wb(1'h0, ADDR_MINUTES_SECONDS, 32'h0);
		`check("locked minutes_seconds_value", 32'h0, rd & 32'h7F00)
		wrap_up();
	end
endmodule
